/* File: cpg_top.sv */
// Channel phase, offset and gain correction stage with register bus.
// Assumes raw conversion results arrive per channel on a valid/ready
// stream, a one-cycle modulator tick, and an AXI4-Lite master.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module cpg_top
	import cpg_pkg::*;
(
	input  wire logic                  clk,       // 125 MHz clock
	input  wire logic                  srst,      // Sync reset, high
	// AXI4-Lite slave
	input  wire logic [7:0]            awaddr,    // Write address
	input  wire logic                  awvalid,   // Address valid
	output logic                       awready,   // Address taken
	input  wire logic [31:0]           wdata,     // Write data
	input  wire logic [3:0]            wstrb,     // Byte enables
	input  wire logic                  wvalid,    // Data valid
	output logic                       wready,    // Data taken
	output logic [1:0]                 bresp,     // Write answer
	output logic                       bvalid,    // Answer valid
	input  wire logic                  bready,    // Answer taken
	input  wire logic [7:0]            araddr,    // Read address
	input  wire logic                  arvalid,   // Address valid
	output logic                       arready,   // Address taken
	output logic [31:0]                rdata,     // Read data
	output logic [1:0]                 rresp,     // Read answer
	output logic                       rvalid,    // Answer valid
	input  wire logic                  rready,    // Answer taken
	// Modulator timing
	input  wire logic                  mod_tick,  // One modulator cycle
	output logic                       conversion_ready_n, // Data ready, low
	// Raw samples in
	input  wire logic                  smp_valid, // Sample offered
	input  wire logic [cpg_pkg::CHW-1:0] smp_ch,  // Its channel
	input  wire logic [cpg_pkg::DW-1:0]  smp_data,// Raw result
	output logic                       smp_ready, // Room for a sample
	// Corrected samples out
	output logic                       out_valid, // Result offered
	output logic [cpg_pkg::CHW-1:0]    out_ch,    // Its channel
	output logic [cpg_pkg::DW-1:0]     out_data,  // Corrected result
	input  wire logic                  out_ready  // Result taken
);
	// Per-channel coefficient store, ratio code and clip count
	logic [9:0]  phase_r [NCH]; // channel_phase_shift
	logic [23:0] off_r   [NCH]; // channel_offset_coef
	logic [23:0] gain_r  [NCH]; // channel_gain_coef
	logic [2:0]  osr_r;         // oversampling_ratio code
	logic [15:0] sat_cnt_r;     // Clipped results seen

	// Effective phases, clipped to the ratio's span
	logic [9:0] eff_ph [NCH];   // Clipped phase per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_clip
			assign eff_ph[g] = cpg_clip(phase_r[g], osr_r);
		end
	endgenerate

	// ---- Write channel ----
	logic      aw_got_r;        // Address held
	logic      w_got_r;         // Data held
	logic [7:0] wa_r;           // Held address
	logic [31:0] wd_r;          // Held data
	logic [3:0] ws_r;           // Held strobes
	cpg_bus_e  wst_r;           // Write state
	wire aw_hs = awvalid && awready; // Address moves
	wire w_hs  = wvalid && wready;   // Data moves
	wire do_wr = (wst_r == CPG_BUS_IDLE) && aw_got_r && w_got_r;

	// Write decode; banks are register-major so all eight channels fit
	wire [7:0] w_rel  = wa_r - A_CHBASE;      // Offset past the base
	wire [2:0] w_ch   = w_rel[4:2];           // Channel index
	wire [2:0] w_reg  = w_rel[CH_SH+2:CH_SH]; // Register bank
	wire       w_chan = (wa_r >= A_CHBASE) && (w_reg <= R_GAIN_L);
	wire       w_ctrl = (wa_r == A_CTRL);
	wire       w_stat = (wa_r == A_STAT);
	wire       w_ok   = w_chan || w_ctrl || w_stat;
	wire       w_b0   = ws_r[0];              // Low byte enable
	wire       w_b1   = ws_r[1];              // Second byte enable
	wire       w_b2   = ws_r[2];              // Third byte enable

	// Address and data may arrive in either order
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			wa_r     <= '0;
			wd_r     <= '0;
			ws_r     <= '0;
		end else begin
			if (aw_hs) begin
				aw_got_r <= 1'b1;
				wa_r     <= awaddr;
			end else if (do_wr) begin
				aw_got_r <= 1'b0;
			end
			if (w_hs) begin
				w_got_r <= 1'b1;
				wd_r    <= wdata;
				ws_r    <= wstrb;
			end else if (do_wr) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// Each ready only while its own item is not held and no answer is pending
	always_ff @(posedge clk) begin
		if (srst) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !aw_got_r && !aw_hs && (wst_r == CPG_BUS_IDLE);
			wready  <= !w_got_r && !w_hs && (wst_r == CPG_BUS_IDLE);
		end
	end

	// Write answer, one at a time
	always_ff @(posedge clk) begin
		if (srst) begin
			wst_r  <= CPG_BUS_IDLE;
			bvalid <= 1'b0;
			bresp  <= RESP_OK;
		end else begin
			unique case (wst_r)
				CPG_BUS_IDLE: begin
					if (do_wr) begin
						wst_r  <= CPG_BUS_RESP;
						bvalid <= 1'b1;
						bresp  <= w_ok ? RESP_OK : RESP_ERR;
					end
				end
				CPG_BUS_RESP: begin
					if (bready) begin
						wst_r  <= CPG_BUS_IDLE;
						bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// Coefficient and control storage
	always_ff @(posedge clk) begin
		if (srst) begin
			osr_r <= OSR_RST;
			for (int i = 0; i < NCH; i++) begin
				phase_r[i] <= PHASE_RST;
				off_r[i]   <= OFF_RST;
				gain_r[i]  <= GAIN_RST;
			end
		end else if (do_wr) begin
			if (w_ctrl && w_b0)
				osr_r <= wd_r[2:0];
			if (w_chan) begin
				unique case (w_reg)
					R_CFG: begin
						if (w_b0)
							phase_r[w_ch][7:0] <= wd_r[7:0];
						if (w_b1)
							phase_r[w_ch][9:8] <= wd_r[9:8];
					end
					R_OFF_U: begin
						if (w_b0)
							off_r[w_ch][15:8] <= wd_r[7:0];
						if (w_b1)
							off_r[w_ch][23:16] <= wd_r[15:8];
					end
					R_OFF_L: begin
						if (w_b0)
							off_r[w_ch][7:0] <= wd_r[7:0];
					end
					R_GAIN_U: begin
						if (w_b0)
							gain_r[w_ch][15:8] <= wd_r[7:0];
						if (w_b1)
							gain_r[w_ch][23:16] <= wd_r[15:8];
					end
					R_GAIN_L: begin
						if (w_b0)
							gain_r[w_ch][7:0] <= wd_r[7:0];
					end
					default: begin
						// Holes in a channel block store nothing
					end
				endcase
			end
		end
	end

	// ---- Read channel ----
	wire [7:0] r_rel  = araddr - A_CHBASE;      // Offset past the base
	wire [2:0] r_ch   = r_rel[4:2];             // Channel index
	wire [2:0] r_reg  = r_rel[CH_SH+2:CH_SH];   // Register bank
	wire       r_chan = (araddr >= A_CHBASE) && (r_reg <= R_GAIN_L);
	wire [3:0] fifo_lv;                         // Buffer fill
	// Read mux; bits above each field read zero
	logic [31:0] r_val;                         // Selected word
	logic        r_ok;                          // Address mapped
	always_comb begin
		r_val = 32'h0000_0000;
		r_ok  = 1'b1;
		if (araddr == A_CTRL)
			r_val = {29'h0, osr_r};
		else if (araddr == A_STAT)
			r_val = {sat_cnt_r, 12'h000, fifo_lv};
		else if (r_chan) begin
			unique case (r_reg)
				R_CFG:    r_val = {6'h00, eff_ph[r_ch], 6'h00, phase_r[r_ch]};
				R_OFF_U:  r_val = {16'h0000, off_r[r_ch][23:8]};
				R_OFF_L:  r_val = {24'h00_0000, off_r[r_ch][7:0]};
				R_GAIN_U: r_val = {16'h0000, gain_r[r_ch][23:8]};
				R_GAIN_L: r_val = {24'h00_0000, gain_r[r_ch][7:0]};
				default:  r_ok = 1'b0;
			endcase
		end else
			r_ok = 1'b0;
	end

	// One read in flight; answer follows the address by one edge
	always_ff @(posedge clk) begin
		if (srst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OK;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= r_val;
				rresp  <= r_ok ? RESP_OK : RESP_ERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ---- Data ready timing ----
	// Latest window end sets when the frame is ready
	logic [9:0]       ph_max;   // Largest clipped phase
	logic [CNT_W-1:0] frame_len;// Ratio in modulator cycles
	logic [CNT_W-1:0] cnt_r;    // Modulator cycle in frame
	logic [CNT_W-1:0] ready_at; // Cycle of ready
	always_comb begin
		ph_max = eff_ph[0];
		for (int i = 1; i < NCH; i++)
			if (signed'(eff_ph[i]) > signed'(ph_max))
				ph_max = eff_ph[i];
	end
	assign frame_len = CNT_W'(14'd128 << osr_r);
	// Negative phases wrap to the frame's end
	assign ready_at = CNT_W'({{4{ph_max[9]}}, ph_max}) & (frame_len - 1'b1);

	// Low for one modulator cycle at the ready point
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r              <= '0;
			conversion_ready_n <= 1'b1;
		end else if (mod_tick) begin
			cnt_r <= (cnt_r >= frame_len - 1'b1) ? '0 : cnt_r + 1'b1;
			conversion_ready_n <= (cnt_r != ready_at);
		end
	end

	// ---- Data path ----
	cpg_stream_if #(.W(PKT_W)) s_raw ();  // Into corrector
	cpg_stream_if #(.W(PKT_W)) s_cor ();  // Into buffer
	cpg_stream_if #(.W(PKT_W)) s_buf ();  // Out of buffer
	logic sat_p;                          // Clip event
	assign s_raw.valid = smp_valid && smp_ready;
	assign s_raw.data  = {smp_ch, smp_data};

	// Coefficients chosen by the arriving sample's channel
	cpg_corr u_corr (
		.clk  (clk),
		.srst (srst),
		.din  (s_raw),
		.dout (s_cor),
		.off  (off_r[smp_ch]),
		.gain (gain_r[smp_ch]),
		.sat  (sat_p)
	);

	cpg_fifo #(.W(PKT_W), .D(FIFO_DEPTH)) u_fifo (
		.clk   (clk),
		.srst  (srst),
		.wr    (s_cor),
		.rd    (s_buf),
		.level (fifo_lv)
	);

	// Registered intake ready keeps margin for the corrector stage
	always_ff @(posedge clk) begin
		if (srst)
			smp_ready <= 1'b0;
		else
			smp_ready <= fifo_lv < 4'(FIFO_DEPTH - FIFO_MARGIN);
	end

	// Output register so every output leaves a flop
	assign s_buf.ready = !out_valid || out_ready;
	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid <= 1'b0;
			out_ch    <= '0;
			out_data  <= '0;
		end else if (s_buf.ready) begin
			out_valid <= s_buf.valid;
			out_ch    <= s_buf.data[PKT_W-1:DW];
			out_data  <= s_buf.data[DW-1:0];
		end
	end

	// Clip counter sticks at its top
	always_ff @(posedge clk) begin
		if (srst)
			sat_cnt_r <= '0;
		else if (sat_p && sat_cnt_r != 16'hFFFF)
			sat_cnt_r <= sat_cnt_r + 1'b1;
	end
endmodule

/* File: cpg_pkg.sv */
// Constants and helpers for the channel phase, offset and gain stage.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package cpg_pkg;
	localparam int NCH        = 8;   // Channel count
	localparam int DW         = 24;  // Sample width
	localparam int PW         = 10;  // Phase field width
	localparam int CHW        = 3;   // Channel index width
	localparam int PKT_W      = 27;  // Channel plus sample
	localparam int FIFO_DEPTH = 8;   // Output buffer depth
	localparam int FIFO_MARGIN = 2;  // Slots kept for the pipe
	localparam int GAIN_FRAC  = 23;  // Gain binary point
	localparam int CNT_W      = 14;  // Modulator cycle counter
	// Register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00; // Ratio select
	localparam logic [7:0] A_STAT   = 8'h04; // Block state
	localparam logic [7:0] A_CHBASE = 8'h40; // First channel
	localparam int         CH_SH    = 5;     // 32 bytes per register bank
	localparam logic [2:0] R_CFG    = 3'h0;  // channel_config
	localparam logic [2:0] R_OFF_U  = 3'h1;  // offset_coef_upper
	localparam logic [2:0] R_OFF_L  = 3'h2;  // offset_coef_lower
	localparam logic [2:0] R_GAIN_U = 3'h3;  // gain_coef_upper
	localparam logic [2:0] R_GAIN_L = 3'h4;  // gain_coef_lower
	// Values after reset
	localparam logic [23:0] OFF_RST   = 24'h00_0000; // No offset
	localparam logic [23:0] GAIN_RST  = 24'h80_0000; // Unity gain
	localparam logic [9:0]  PHASE_RST = 10'h000;     // Zero phase
	localparam logic [2:0]  OSR_RST   = 3'h3;        // Ratio 1024
	localparam logic [1:0]  RESP_OK   = 2'h0;        // OKAY
	localparam logic [1:0]  RESP_ERR  = 2'h2;        // SLVERR
	// Ratio select code 0..7 means 128 << code
	typedef enum logic [0:0] {
		CPG_BUS_IDLE = 1'b0, // Waiting
		CPG_BUS_RESP = 1'b1  // Answer pending
	} cpg_bus_e;
	// Clip a phase code to the span allowed at a ratio
	function automatic logic [9:0] cpg_clip(logic [9:0] ph,
			logic [2:0] code);
		logic signed [10:0] half;
		logic signed [10:0] v;
		half = (code >= 3'h3) ? 11'sd512 : (11'sd64 <<< code);
		v = {ph[9], ph};
		if (v > half - 11'sd1)
			v = half - 11'sd1;
		else if (v < -half)
			v = -half;
		return v[9:0];
	endfunction
endpackage

/* File: cpg_stream_if.sv */
// Valid/ready carrier between the stage's internal modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface cpg_stream_if #(parameter int W = 27);
	logic         valid; // Item offered
	logic         ready; // Item can move
	logic [W-1:0] data;  // Channel and sample
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

/* File: cpg_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty come from the stored count.
`timescale 1ns/1ps
module cpg_fifo #(
	parameter int W = 27, // Item width
	parameter int D = 8   // Depth
) (
	input  wire logic     clk,   // Clock
	input  wire logic     srst,  // Sync reset
	cpg_stream_if.snk     wr,    // Filling side
	cpg_stream_if.src     rd,    // Draining side
	output logic [3:0]    level  // Items held
);
	localparam int AW = $clog2(D); // Pointer width
	logic [W-1:0]  mem [D];        // Storage
	logic [AW-1:0] wp_r;           // Write pointer
	logic [AW-1:0] rp_r;           // Read pointer
	logic [AW:0]   cnt_r;          // Fill count
	wire push = wr.valid && wr.ready; // Write moves
	wire pop  = rd.valid && rd.ready; // Read moves
	// Honest flags from the count
	assign wr.ready = (cnt_r != (AW+1)'(D));
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem[rp_r];
	assign level    = 4'(cnt_r);
	// Storage is not reset; only valid slots are ever read
	always_ff @(posedge clk) begin
		if (push)
			mem[wp_r] <= wr.data;
	end
	// Pointers and count
	always_ff @(posedge clk) begin
		if (srst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: cpg_corr.sv */
// One-stage offset and gain corrector with saturation.
// Assumes coefficients are selected by the caller for the item's channel.
`timescale 1ns/1ps
module cpg_corr
	import cpg_pkg::*;
(
	input  wire logic        clk,   // Clock
	input  wire logic        srst,  // Sync reset
	cpg_stream_if.snk        din,   // Raw samples
	cpg_stream_if.src        dout,  // Corrected samples
	input  wire logic [23:0] off,   // Offset, signed
	input  wire logic [23:0] gain,  // Gain, unsigned Q1.23
	output logic             sat    // Clip pulse
);
	logic               v_r;   // Stage full
	logic [PKT_W-1:0]   d_r;   // Stage data
	logic signed [24:0] diff;  // Sample minus offset
	logic signed [49:0] prod;  // Scaled difference
	logic signed [26:0] q;     // Product at sample scale
	logic [23:0]        res;   // Clipped result
	logic               clip;  // Result clipped
	// Offset first, then gain
	assign diff = 25'(signed'(din.data[23:0])) - 25'(signed'(off));
	assign prod = 50'(diff) * signed'({1'b0, gain});
	assign q    = 27'(prod >>> GAIN_FRAC);
	// Clip instead of wrap
	assign clip = (q > 27'sd8388607) || (q < -27'sd8388608);
	assign res  = !clip ? q[23:0] :
		(q[26] ? 24'h80_0000 : 24'h7F_FFFF);
	assign din.ready = !v_r || dout.ready;
	assign dout.valid = v_r;
	assign dout.data  = d_r;
	// Stage register, holds while the buffer is full
	always_ff @(posedge clk) begin
		if (srst) begin
			v_r <= 1'b0;
			d_r <= '0;
			sat <= 1'b0;
		end else begin
			sat <= din.valid && din.ready && clip;
			if (din.ready) begin
				v_r <= din.valid;
				d_r <= {din.data[PKT_W-1:24], res};
			end
		end
	end
endmodule

/* File: cpg_top_monitor.sv */
// Port-level checker for the correction stage top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module cpg_top_monitor (
	input wire logic        clk,                // Clock
	input wire logic        srst,               // Sync reset
	input wire logic        awvalid,            // Address offered
	input wire logic        awready,            // Address taken
	input wire logic        wvalid,             // Data offered
	input wire logic        wready,             // Data taken
	input wire logic [1:0]  bresp,              // Write answer
	input wire logic        bvalid,             // Answer valid
	input wire logic        bready,             // Answer taken
	input wire logic        arvalid,            // Read address
	input wire logic        arready,            // Read taken
	input wire logic [31:0] rdata,              // Read data
	input wire logic        rvalid,             // Data valid
	input wire logic        rready,             // Data taken
	input wire logic        mod_tick,           // Modulator cycle
	input wire logic        conversion_ready_n, // Ready, low
	input wire logic        smp_valid,          // Sample offered
	input wire logic        smp_ready,          // Sample room
	input wire logic        out_valid,          // Result offered
	input wire logic [2:0]  out_ch,             // Result channel
	input wire logic [23:0] out_data,           // Result value
	input wire logic        out_ready           // Result taken
);
	// One domain, so one clocking and one disable
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer moved while waiting");
	chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data moved while waiting");
	chk_out_hold: assert property (out_valid && !out_ready |=>
		out_valid && $stable({out_ch, out_data}))
		else $error("corrected sample moved while stalled");
	chk_ar_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
		else $error("read answer late");
	chk_b_answer: assert property (awvalid && awready && wvalid && wready
		|-> ##[1:3] bvalid)
		else $error("write answer late");
	chk_aw_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	chk_ar_refuse: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	// Bound keeps stalls of the bench well inside the window
	chk_out_latency: assert property (smp_valid && smp_ready |->
		##[1:800] out_valid)
		else $error("accepted sample never offered");
	// Ready line may only move on the modulator cadence
	chk_ready_tick: assert property ($changed(conversion_ready_n) |->
		$past(mod_tick) || $past(mod_tick, 2) || $past(mod_tick, 3))
		else $error("ready line moved without a modulator tick");
	chk_rst_quiet: assert property ($fell(srst) |-> !bvalid && !rvalid
		&& !out_valid && conversion_ready_n)
		else $error("outputs active right after reset");

	cov_stream: cover property (out_valid && out_ready);
	cov_full: cover property (smp_valid && !smp_ready);
	cov_tick: cover property ($fell(conversion_ready_n));
	cov_read: cover property (rvalid && rready);
endmodule

/* File: cpg_host_sink.sv */
// Host-side model that takes corrected samples with random stalls.
// Assumes the bench can force a long stall through hold.
`timescale 1ns/1ps
module cpg_host_sink (
	input  wire logic clk,       // Clock
	input  wire logic srst,      // Sync reset
	input  wire logic hold,      // Bench-commanded stall
	output logic      out_ready  // Sample taken
);
	// Whole-sample realignment stays in host software, not here
	// Random back-pressure, like a host busy with other traffic
	always @(posedge clk) begin
		out_ready <= !srst && !hold && ($urandom % 4 != 0);
	end
endmodule

/* File: tb_channel_phase_gain_offset_cal.sv */
// Self-checking bench for the correction stage top module.
// Assumes cpg_pkg, the host sink model and the port checker.
`timescale 1ns/1ps
module tb_channel_phase_gain_offset_cal;
	import cpg_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cpg_rd_s;
	logic        clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, mod_tick;
	logic        smp_valid, smp_ready, out_valid, out_ready, hold;
	logic        conversion_ready_n;
	logic [7:0]  awaddr, araddr;   // Bus addresses
	logic [31:0] wdata, rdata;     // Bus data
	logic [3:0]  wstrb;            // Byte lanes
	logic [1:0]  bresp, rresp;     // Answers
	logic [2:0]  smp_ch, out_ch;   // Channels
	logic [23:0] smp_data, out_data;
	logic [23:0] off_a [8];        // Offsets in force
	logic [23:0] gn_a [8];         // Gains in force
	logic [9:0]  phs [4];          // Phase codes tried
	logic [26:0] sq [$];           // Expected samples
	logic [1:0]  bq [$];           // Expected write answers
	cpg_rd_s     rq [$];           // Expected read answers
	cpg_rd_s     rx;               // Popped read note
	int          n_mismatch, n_checks;
	logic        rdy_q;            // Ready line one edge ago
	int          tick_n;           // Ticks since the last fall

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	cpg_top dut (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .mod_tick,
		.conversion_ready_n, .smp_valid, .smp_ch, .smp_data, .smp_ready,
		.out_valid, .out_ch, .out_data, .out_ready);
	cpg_host_sink u_host (.clk, .srst, .hold, .out_ready);
	// Irregular modulator cadence, quiet during reset
	always @(posedge clk) begin
		mod_tick <= !srst && ($urandom % 3 == 0);
	end
	// Modulator ticks counted from each fall of the ready line
	always @(posedge clk) begin
		rdy_q <= conversion_ready_n;
		tick_n <= (rdy_q && !conversion_ready_n) ? int'(mod_tick)
			: tick_n + int'(mod_tick);
	end

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo(input string nm);
		$display("CHECK FAILED %s expected handshake seen timeout", nm);
		n_mismatch++;
		tally_and_finish();
	endtask
	// Reference correction: offset first, then gain, then clamp
	function automatic logic [23:0] corr(logic [23:0] d, o, g);
		logic signed [24:0] df;
		logic signed [49:0] p;
		df = $signed({d[23], d}) - $signed({o[23], o});
		p = df * $signed({1'b0, g});
		p = p >>> GAIN_FRAC;
		if (p > 50'sh7F_FFFF) return 24'h7F_FFFF;
		if (p < -50'sh80_0000) return 24'h80_0000;
		return p[23:0];
	endfunction
	function automatic logic [9:0] clipx(logic [9:0] p, int code);
		int h, v;
		h = (code >= 3) ? 512 : (64 << code);
		v = $signed(p);
		if (v > h - 1) v = h - 1;
		if (v < -h) v = -h;
		return v[9:0];
	endfunction
	// One bank per register, one word per channel in each bank
	function automatic logic [7:0] ra(int c, logic [2:0] r);
		return A_CHBASE + (8'(r) << CH_SH) + 8'(c << 2);
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] e);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bq.push_back(e);
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			bready <= bvalid;
		end
		bready <= 1'b0;
		if (i == 200) tmo("bvalid");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [1:0] e);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rq.push_back('{d, m, e});
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			rready <= rvalid;
		end
		rready <= 1'b0;
		if (i == 200) tmo("rvalid");
	endtask
	// Leaves valid high so calls can run back to back
	task automatic send(input logic [2:0] c, input logic [23:0] d);
		int i;
		smp_valid <= 1'b1;
		smp_ch <= c;
		smp_data <= d;
		sq.push_back({c, corr(d, off_a[c], gn_a[c])});
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if (smp_ready) break;
		end
		if (i == 300) tmo("smp_ready");
	endtask
	task automatic wcoef(input int c);
		wr(ra(c, R_OFF_U), {16'h0, off_a[c][23:8]}, RESP_OK);
		wr(ra(c, R_OFF_L), {24'h0, off_a[c][7:0]}, RESP_OK);
		wr(ra(c, R_GAIN_U), {16'h0, gn_a[c][23:8]}, RESP_OK);
		wr(ra(c, R_GAIN_L), {24'h0, gn_a[c][7:0]}, RESP_OK);
	endtask
	task automatic drain;
		int i;
		for (i = 0; i < 3000 && sq.size() != 0; i++) @(posedge clk);
		if (sq.size() != 0) tmo("out_valid");
		repeat (3) @(posedge clk);
	endtask
	// Waits for a fall of the ready line; e below zero only syncs
	task automatic wfall(input int e);
		int i;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk);
			if (rdy_q && !conversion_ready_n) break;
		end
		if (i == 1000) tmo("conversion_ready_n");
		else if (e >= 0) chk("ready ticks", 32'(e), 32'(tick_n));
	endtask

	// Result watcher: oldest note against each answer seen
	always @(posedge clk) begin
		if (bvalid && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
		if (rvalid && rready) begin
			rx = rq.pop_front();
			chk("rdata", rx.d & rx.m, rdata & rx.m);
			chk("rresp", 32'(rx.r), 32'(rresp));
		end
		if (out_valid && out_ready)
			chk("sample", 32'(sq.pop_front()), {5'h0, out_ch, out_data});
	end

	initial begin
		int c, k;
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, smp_valid, hold} = '0;
		{awaddr, araddr, wdata, smp_ch, smp_data} = '0;
		wstrb = 4'hF;
		for (c = 0; c < 8; c++) begin
			off_a[c] = OFF_RST;
			gn_a[c] = GAIN_RST;
		end
		void'($urandom(9703));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		// Coefficient and ratio values after reset
		for (c = 0; c < 8; c++) begin
			rd(ra(c, R_GAIN_U), 32'h0000_8000, 32'h0000_FFFF, RESP_OK);
			rd(ra(c, R_OFF_L), 32'h0000_0000, 32'h0000_00FF, RESP_OK);
		end
		rd(A_CTRL, 32'h0000_0003, 32'h0000_0007, RESP_OK);
		$display("reset values test done");
		// Default coefficients pass samples unchanged
		for (c = 0; c < 8; c++) send(c[2:0], 24'($urandom));
		smp_valid <= 1'b0;
		drain();
		$display("default pass-through test done");
		// Host loads coefficients; zero gain and clamp cases included
		for (c = 0; c < 8; c++) begin
			off_a[c] = (c == 5) ? 24'h80_0000 : 24'($urandom);
			gn_a[c] = (c == 4) ? 24'h0 : (c == 5) ? 24'hFF_FFFF : 24'($urandom);
			wcoef(c);
		end
		send(3'd5, 24'h7F_FFFF);
		for (k = 0; k < 24; k++) send(k[2:0], 24'($urandom));
		smp_valid <= 1'b0;
		drain();
		$display("offset and gain test done");
		// Phase clipping for ratio codes 0 to 4, sign included
		phs = '{10'd100, 10'h39C, 10'h200, 10'($urandom)};
		for (c = 0; c < 5; c++) begin
			wr(A_CTRL, 32'(c), RESP_OK);
			for (k = 0; k < 4; k++) begin
				wr(ra(0, R_CFG), {22'h0, phs[k]}, RESP_OK);
				rd(ra(0, R_CFG), {6'h0, clipx(phs[k], c), 16'h0},
					32'h03FF_0000, RESP_OK);
			end
		end
		$display("phase clip test done");
		// Ready line: frame of 128 ticks, then moved by a clipped phase
		wr(A_CTRL, 32'h0, RESP_OK);
		wr(ra(0, R_CFG), 32'd10, RESP_OK);
		wfall(-1);
		wfall(128);
		wr(ra(0, R_CFG), 32'd100, RESP_OK);
		wfall(53);
		$display("ready timing test done");
		// Holes answer with an error and store nothing
		rd(8'h08, 32'h0, 32'hFFFF_FFFF, RESP_ERR);
		wr(8'h3C, 32'h1234_5678, RESP_ERR);
		$display("unmapped access test done");
		// Host stalls until the buffer refuses, then drains it
		hold <= 1'b1;
		fork
			begin
				for (k = 0; k < 12; k++) send(k[2:0], 24'($urandom));
				smp_valid <= 1'b0;
			end
			begin
				repeat (40) @(posedge clk);
				chk("smp_ready", 32'h0, {31'h0, smp_ready});
				hold <= 1'b0;
			end
		join
		drain();
		rd(A_STAT, 32'h0, 32'h0000_000F, RESP_OK);
		$display("buffer fill test done");
		drain();
		tally_and_finish();
	end
endmodule

bind cpg_top cpg_top_monitor u_mon (.clk, .srst, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
	.rvalid, .rready, .mod_tick, .conversion_ready_n, .smp_valid,
	.smp_ready, .out_valid, .out_ch, .out_data, .out_ready);
